/* File: adcc_top.sv */
// A/D conversion control: Avalon-MM register slave, start/abort control,
// result registers with end-of-conversion conflict handling, interrupt.
// Assumes one clock, an external comparator, and a master that holds each
// request until it sees waitrequest low.
//
// Our own choices: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "adcc_defines.svh"

module adcc_top
(
  input  wire logic                     clk_sys,
  input  wire logic                     nrst,
  input  wire adcc_pkg::adcc_av_req_t   av_req,
  output adcc_pkg::adcc_av_rsp_t        av_rsp,
  input  wire logic                     comp_in,
  output logic [`ADCC_RES_W-1:0]        dac_code,
  output logic                          sample_en,
  output logic [`ADCC_CHAN_W-1:0]       channel_select_reg,
  output logic [7:0]                    port_analog_mode_reg,
  output logic                          conversion_done_irq
);
  import adcc_pkg::*;

  logic                    rst_q1, rst_n_r;
  logic                    wait_r,  wait_nxt;
  logic [31:0]             rdata_r, rdata_nxt;
  logic                    start_r, start_nxt;
  logic                    en_r,    en_nxt;
  logic [`ADCC_CHAN_W-1:0] chan_nxt;
  logic [7:0]              pmode_nxt;
  logic [`ADCC_RES_W-1:0]  res_r,   res_nxt;
  logic [`ADCC_RES_W-1:0]  hold_r,  hold_nxt;
  logic                    pend_r,  pend_nxt;
  logic                    flag_r,  flag_nxt;
  logic                    mask_r,  mask_nxt;
  logic                    irq_nxt;
  logic                    wr_fire, mode_wr, res_rd_busy, commit, go;
  logic                    seq_done, seq_busy;
  logic [`ADCC_RES_W-1:0]  seq_res;

  // ==========================================================
  // Reset release
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_q1  <= 1'b0;
      rst_n_r <= 1'b0;
    end
    else
    begin
      rst_q1  <= 1'b1;
      rst_n_r <= rst_q1;
    end
  end

  function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
    hit = (a == r);
  endfunction

  function automatic logic [31:0] rd_mux(input logic [3:0] a);
    rd_mux = 32'h0;
    case (a)
      `ADCC_A_MODE:  rd_mux = {24'h0, start_r, 6'h0, en_r};
      `ADCC_A_CHAN:  rd_mux = {29'h0, channel_select_reg};
      `ADCC_A_PMODE: rd_mux = {24'h0, port_analog_mode_reg};
      `ADCC_A_RESH:  rd_mux = {24'h0, res_r[`ADCC_RES_W-1:2]};
      `ADCC_A_RESL:  rd_mux = {30'h0, res_r[1:0]};
      `ADCC_A_STAT:  rd_mux = {31'h0, flag_r};
      `ADCC_A_MASK:  rd_mux = {31'h0, mask_r};
      default:       rd_mux = 32'h0;
    endcase
  endfunction

  // ==========================================================
  // Bus handshake: one wait cycle, then a one-cycle acceptance
  assign wr_fire     = av_req.write && !wait_r;
  assign mode_wr     = wr_fire && hit(av_req.address, `ADCC_A_MODE);
  // Whole read phase counts, so the captured data and the update never mix
  assign res_rd_busy = av_req.read && (hit(av_req.address, `ADCC_A_RESH)
                                    || hit(av_req.address, `ADCC_A_RESL));
  assign commit      = (seq_done || pend_r) && !res_rd_busy && !mode_wr;
  // A start landing on the done cycle must not leave start stuck high
  assign go          = mode_wr && av_req.writedata[`ADCC_MODE_START]
                    && av_req.writedata[`ADCC_MODE_EN] && (!start_r || seq_done);

  always_comb
  begin
    wait_nxt  = 1'b1;
    rdata_nxt = rdata_r;
    if ((av_req.read || av_req.write) && wait_r)
    begin
      wait_nxt = 1'b0;
      if (av_req.read)
        rdata_nxt = rd_mux(av_req.address);
    end
  end

  // ==========================================================
  // Control, result and interrupt state
  always_comb
  begin
    start_nxt = start_r;
    en_nxt    = en_r;
    chan_nxt  = channel_select_reg;
    pmode_nxt = port_analog_mode_reg;
    mask_nxt  = mask_r;
    flag_nxt  = flag_r;
    res_nxt   = res_r;
    hold_nxt  = hold_r;
    pend_nxt  = pend_r;
    if (seq_done)
    begin
      start_nxt = 1'b0;
      hold_nxt  = seq_res;
    end
    if (mode_wr)
    begin
      en_nxt    = av_req.writedata[`ADCC_MODE_EN];
      // Start only takes while enabled; clearing it aborts the run
      start_nxt = av_req.writedata[`ADCC_MODE_START]
               && av_req.writedata[`ADCC_MODE_EN];
      pend_nxt  = 1'b0;
    end
    else if (seq_done && res_rd_busy)
      pend_nxt = 1'b1;
    if (wr_fire && hit(av_req.address, `ADCC_A_CHAN))
      chan_nxt = av_req.writedata[`ADCC_CHAN_W-1:0];
    if (wr_fire && hit(av_req.address, `ADCC_A_PMODE))
      pmode_nxt = av_req.writedata[7:0];
    // Result left as is on such writes; software must not trust it
    if (wr_fire && hit(av_req.address, `ADCC_A_MASK))
      mask_nxt = av_req.writedata[`ADCC_ST_DONE];
    if (wr_fire && hit(av_req.address, `ADCC_A_STAT)
        && av_req.writedata[`ADCC_ST_DONE])
      flag_nxt = 1'b0;
    if (commit)
    begin
      res_nxt  = seq_done ? seq_res : hold_r;
      pend_nxt = 1'b0;
      flag_nxt = 1'b1; // Set beats a same-cycle clear
    end
    irq_nxt = flag_nxt && mask_nxt;
  end

  always_ff @(posedge clk_sys or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      wait_r               <= 1'b1;
      rdata_r              <= 32'h0;
      start_r              <= 1'b0;
      en_r                 <= 1'b0;
      channel_select_reg   <= `ADCC_CHAN_RST;
      port_analog_mode_reg <= `ADCC_BYTE_RST;
      mask_r               <= 1'b0;
      flag_r               <= 1'b0;
      res_r                <= `ADCC_RES_RST;
      hold_r               <= `ADCC_RES_RST;
      pend_r               <= 1'b0;
      conversion_done_irq  <= 1'b0;
    end
    else
    begin
      wait_r               <= wait_nxt;
      rdata_r              <= rdata_nxt;
      start_r              <= start_nxt;
      en_r                 <= en_nxt;
      channel_select_reg   <= chan_nxt;
      port_analog_mode_reg <= pmode_nxt;
      mask_r               <= mask_nxt;
      flag_r               <= flag_nxt;
      res_r                <= res_nxt;
      hold_r               <= hold_nxt;
      pend_r               <= pend_nxt;
      conversion_done_irq  <= irq_nxt;
    end
  end

  assign av_rsp.waitrequest = wait_r;
  assign av_rsp.readdata    = rdata_r;

  // ==========================================================
  // Sequencer
  adcc_sar_seq u_seq
  (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n_r),
    .go        (go),
    .run       (start_r),
    .comp_in   (comp_in),
    .done      (seq_done),
    .result    (seq_res),
    .dac_code  (dac_code),
    .sample_en (sample_en),
    .busy      (seq_busy)
  );

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n_r);

  property p_rd_first;
    seq_done && res_rd_busy && !mode_wr |=> pend_r && res_r == $past(res_r)
      ##[0:8] (res_r == hold_r && flag_r);
  endproperty
  a_rd_first: assert property (p_rd_first) else $error("result overwrote a read");

  property p_mode_wins;
    seq_done && mode_wr && !pend_r |=> res_r == $past(res_r) && !pend_r;
  endproperty
  a_mode_wins: assert property (p_mode_wins) else $error("mode write lost to result");

  property p_chan_keeps_flag;
    wr_fire && hit(av_req.address, `ADCC_A_CHAN) && flag_r |=> flag_r;
  endproperty
  a_chan_keeps_flag: assert property (p_chan_keeps_flag) else $error("flag lost");

  property p_done_clears_start;
    seq_done && !mode_wr |=> !start_r && !seq_busy;
  endproperty
  a_done_clears_start: assert property (p_done_clears_start) else $error("start held");

  property p_commit_flags;
    seq_done && !res_rd_busy && !mode_wr |=> flag_r && res_r == $past(seq_res);
  endproperty
  a_commit_flags: assert property (p_commit_flags) else $error("result not stored");

  property p_abort;
    $fell(start_r) && seq_busy && !$past(seq_done) |=> !seq_busy;
  endproperty
  a_abort: assert property (p_abort) else $error("abort ignored");

  property p_disabled_start;
    mode_wr && !av_req.writedata[`ADCC_MODE_EN] |=> !start_r ##1 !seq_busy;
  endproperty
  a_disabled_start: assert property (p_disabled_start) else $error("start while off");

  property p_res_reset;
    $rose(rst_n_r) |-> res_r == `ADCC_RES_RST && !flag_r;
  endproperty
  a_res_reset: assert property (p_res_reset) else $error("result not cleared");

  property p_irq_level;
    flag_r && mask_r |-> ##[0:1] conversion_done_irq;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt missing");

  property p_bus_answer;
    (av_req.read || av_req.write) && wait_r |=> !wait_r;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("bus not answered");

  property p_rd_commit;
    pend_r && !seq_done && !res_rd_busy && !mode_wr
      |=> !pend_r && flag_r && res_r == $past(hold_r);
  endproperty
  a_rd_commit: assert property (p_rd_commit) else $error("held result not written");

  property p_write_keeps_result;
    wr_fire && !commit
      && (hit(av_req.address, `ADCC_A_CHAN) || hit(av_req.address, `ADCC_A_PMODE))
      |=> res_r == $past(res_r);
  endproperty
  a_write_keeps_result: assert property (p_write_keeps_result) else $error("result changed");

  property p_flag_sticky;
    flag_r
      && !(wr_fire && hit(av_req.address, `ADCC_A_STAT) && av_req.writedata[`ADCC_ST_DONE])
      |=> flag_r;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped");

  property p_go_runs;
    go |=> start_r && seq_busy;
  endproperty
  a_go_runs: assert property (p_go_runs) else $error("start did not run");

  property p_start_needs_en;
    start_r |-> en_r;
  endproperty
  a_start_needs_en: assert property (p_start_needs_en) else $error("start without enable");

  property p_irq_needs_flag;
    !flag_r |-> !conversion_done_irq;
  endproperty
  a_irq_needs_flag: assert property (p_irq_needs_flag) else $error("interrupt without flag");

  property p_wait_one;
    !wait_r |=> wait_r;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("waitrequest low too long");

  property p_res_high_read;
    !wait_r && av_req.read && hit(av_req.address, `ADCC_A_RESH)
      |-> av_rsp.readdata == {24'h0, res_r[`ADCC_RES_W-1:2]};
  endproperty
  a_res_high_read: assert property (p_res_high_read) else $error("high result misread");

  c_conv_done:   cover property (seq_done ##1 flag_r);
  c_rd_conflict: cover property (seq_done && res_rd_busy);
  c_mode_clash:  cover property (seq_done && mode_wr);
  c_abort:       cover property ($fell(start_r) && seq_busy);
  c_pend_commit: cover property (pend_r ##1 !pend_r && flag_r);

endmodule

/* File: adcc_defines.svh */
// Constants for the A/D conversion control block: register map, field
// positions, reset values and sequencer timing.
// Assumes inclusion by bare name from the package and the design modules.
//
// Notes on behaviour
// - A result-register read at conversion end finishes first; new result written afterwards.
// - A mode write at conversion end wins; result kept, no completion interrupt.
// - Changing the channel selection never clears the completion flag.
// - Mode, channel or port-analog writes may leave result contents undefined.
// - Start runs one conversion; end stores result, raises flag, clears start bit.
// - Clearing start during a conversion aborts it and returns to standby, except in its last decision cycle, where it completes.
// - Start written while the converter is disabled is ignored.
// - Upper eight result bits in high register, lower two in low; reset clears both.
`ifndef ADCC_DEFINES_SVH
`define ADCC_DEFINES_SVH

// ==========================================================
// Register map (word addresses)
`define ADCC_A_MODE   4'h0
`define ADCC_A_CHAN   4'h1
`define ADCC_A_PMODE  4'h2
`define ADCC_A_RESH   4'h3
`define ADCC_A_RESL   4'h4
`define ADCC_A_STAT   4'h5
`define ADCC_A_MASK   4'h6

// ==========================================================
// Fields and reset values
`define ADCC_MODE_START  7
`define ADCC_MODE_EN     0
`define ADCC_ST_DONE     0
`define ADCC_CHAN_W      3
`define ADCC_RES_W       10
`define ADCC_RES_MSB     10'h200
`define ADCC_RES_RST     10'h000
`define ADCC_BYTE_RST    8'h00
`define ADCC_CHAN_RST    3'h0

// ==========================================================
// Sequencer timing in clk_sys cycles, and the index of the first bit decided (the MSB)
`define ADCC_SAMPLE_CYC  4'h4
`define ADCC_STEP_CYC    2'h3
`define ADCC_BIT_LAST    4'h9
`define ADCC_CONV_CYC    16'h0022

`endif

/* File: adcc_pkg.sv */
// Types shared by the A/D conversion control block.
// Assumes adcc_defines.svh is on the include path.
`include "adcc_defines.svh"

package adcc_pkg;

  typedef struct packed
  {
    logic        read;
    logic        write;
    logic [3:0]  address;
    logic [31:0] writedata;
  } adcc_av_req_t;

  typedef struct packed
  {
    logic        waitrequest;
    logic [31:0] readdata;
  } adcc_av_rsp_t;

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_SAMPLE, SEQ_CONV} adcc_seq_st_t;

endpackage

/* File: adcc_sar_seq.sv */
// Successive-approximation sequencer: sampling, then ten bit decisions.
// Assumes an external comparator that is high when the input >= dac_code,
// asynchronous to clk_sys; reset is already synchronised.
`timescale 1ns/1ps
`include "adcc_defines.svh"

module adcc_sar_seq
(
  input  wire logic                    clk_sys,
  input  wire logic                    rst_n,
  input  wire logic                    go,
  input  wire logic                    run,
  input  wire logic                    comp_in,
  output logic                         done,
  output logic [`ADCC_RES_W-1:0]       result,
  output logic [`ADCC_RES_W-1:0]       dac_code,
  output logic                         sample_en,
  output logic                         busy
);
  import adcc_pkg::*;

  adcc_seq_st_t            st_r,   st_nxt;
  logic [3:0]              cnt_r,  cnt_nxt;
  logic [1:0]              stp_r,  stp_nxt;
  logic [`ADCC_RES_W-1:0]  sar_r,  sar_nxt;
  logic [`ADCC_RES_W-1:0]  res_nxt;
  logic                    done_nxt;
  logic                    cmp_q1, cmp_q2;

  // ==========================================================
  // Comparator synchroniser
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cmp_q1 <= 1'b0;
      cmp_q2 <= 1'b0;
    end
    else
    begin
      cmp_q1 <= comp_in;
      cmp_q2 <= cmp_q1;
    end
  end

  // ==========================================================
  // Sequencer
  always_comb
  begin
    st_nxt   = st_r;
    cnt_nxt  = cnt_r;
    stp_nxt  = stp_r;
    sar_nxt  = sar_r;
    res_nxt  = result;
    done_nxt = 1'b0;
    case (st_r)
      SEQ_IDLE:
        if (go)
        begin
          st_nxt  = SEQ_SAMPLE;
          cnt_nxt = 4'h0;
        end
      SEQ_SAMPLE:
        if (!run)
          st_nxt = SEQ_IDLE;
        else if (cnt_r == `ADCC_SAMPLE_CYC - 4'h1)
        begin
          st_nxt  = SEQ_CONV;
          cnt_nxt = `ADCC_BIT_LAST;
          stp_nxt = 2'h0;
          sar_nxt = `ADCC_RES_MSB;
        end
        else
          cnt_nxt = cnt_r + 4'h1;
      SEQ_CONV:
        if (!run)
          st_nxt = SEQ_IDLE;
        else if (stp_r != `ADCC_STEP_CYC - 2'h1)
          stp_nxt = stp_r + 2'h1; // Let the sync see the settled tap
        else
        begin
          // MSB first; drop the trial bit when the input is below the tap
          stp_nxt = 2'h0;
          if (!cmp_q2)
            sar_nxt[cnt_r] = 1'b0;
          if (cnt_r == 4'h0)
          begin
            st_nxt   = SEQ_IDLE;
            res_nxt  = sar_nxt;
            done_nxt = 1'b1;
          end
          else
          begin
            cnt_nxt = cnt_r - 4'h1;
            sar_nxt[cnt_r - 4'h1] = 1'b1;
          end
        end
      default:
        st_nxt = SEQ_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r      <= SEQ_IDLE;
      cnt_r     <= 4'h0;
      stp_r     <= 2'h0;
      sar_r     <= `ADCC_RES_RST;
      result    <= `ADCC_RES_RST;
      done      <= 1'b0;
      dac_code  <= `ADCC_RES_RST;
      sample_en <= 1'b0;
      busy      <= 1'b0;
    end
    else
    begin
      st_r      <= st_nxt;
      cnt_r     <= cnt_nxt;
      stp_r     <= stp_nxt;
      sar_r     <= sar_nxt;
      result    <= res_nxt;
      done      <= done_nxt;
      dac_code  <= sar_nxt;
      sample_en <= (st_nxt == SEQ_SAMPLE);
      busy      <= (st_nxt != SEQ_IDLE);
    end
  end

  // ==========================================================
  // Checks
  logic [15:0] run_cnt_r;
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      run_cnt_r <= 16'h0000;
    else if (st_r == SEQ_IDLE)
      run_cnt_r <= 16'h0000;
    else
      run_cnt_r <= run_cnt_r + 16'h0001;
  end

  property p_conv_length;
    @(posedge clk_sys) disable iff (!rst_n)
    $rose(done) |-> run_cnt_r == `ADCC_CONV_CYC;
  endproperty
  a_conv_length: assert property (p_conv_length) else $error("conversion length wrong");

endmodule

/* File: adcc_tb.sv */
// Self-checking bench for the A/D conversion control block.
// Assumes adcc_pkg and adcc_top are compiled first; the comparator is ideal.
`timescale 1ns/1ps
`include "adcc_defines.svh"

module testbench;
  import adcc_pkg::*;

  logic                    clk_sys;
  logic                    nrst;
  adcc_av_req_t            av_req;
  adcc_av_rsp_t            av_rsp;
  logic                    comp_in;
  logic [`ADCC_RES_W-1:0]  dac_code;
  logic                    sample_en;
  logic [`ADCC_CHAN_W-1:0] chan;
  logic [7:0]              pmode;
  logic                    irq;
  logic [9:0]              ain;
  logic [9:0]              prev;
  logic [9:0]              v;
  logic [9:0]              r;
  logic [31:0]             q;
  logic [31:0]             q2;
  logic                    ok;
  int                      n_errors;
  int                      tests_run;
  int                      n_samp;
  int                      base;
  int                      seen_set;
  int                      seen_keep;
  logic [9:0]              vals [4];

  // Ideal comparator; synchroniser latency is inside the design
  assign comp_in = (ain >= dac_code);

  adcc_top i_dut
  (
    .clk_sys              (clk_sys),
    .nrst                 (nrst),
    .av_req               (av_req),
    .av_rsp               (av_rsp),
    .comp_in              (comp_in),
    .dac_code             (dac_code),
    .sample_en            (sample_en),
    .channel_select_reg   (chan),
    .port_analog_mode_reg (pmode),
    .conversion_done_irq  (irq)
  );

  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys)
    if (sample_en === 1'b1) n_samp <= n_samp + 1;

  // ==========================================================
  // Reporting
  task complete_run;
    $display("errors %0d, comparisons %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // ==========================================================
  // Avalon-MM master: hold request until waitrequest low is sampled
  task acc(input logic wr_n_rd, input logic [3:0] a, input logic [31:0] d);
    int n;
    av_req.read      <= ~wr_n_rd;
    av_req.write     <= wr_n_rd;
    av_req.address   <= a;
    av_req.writedata <= d;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (av_rsp.waitrequest !== 1'b0 && n < 20);
    q = av_rsp.readdata;
    if (av_rsp.waitrequest !== 1'b0)
    begin
      n_errors++;
      $display("ERROR t=%0t bus request not answered", $time);
      complete_run();
    end
    av_req.read  <= 1'b0;
    av_req.write <= 1'b0;
    // Idle edge so the next request never lands in the same time step
    @(posedge clk_sys);
  endtask

  task wr(input logic [3:0] a, input logic [31:0] d);
    acc(1'b1, a, d);
  endtask

  task rd(input logic [3:0] a, input logic [31:0] exp, input string msg);
    acc(1'b0, a, 32'h0);
    chk(q, exp, msg);
  endtask

  task cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task wait_irq;
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 100)
    begin
      @(posedge clk_sys);
      n++;
    end
    if (irq !== 1'b1)
    begin
      n_errors++;
      $display("ERROR t=%0t no completion interrupt", $time);
      complete_run();
    end
  endtask

  task read_result;
    acc(1'b0, `ADCC_A_RESH, 32'h0);
    q2 = q;
    acc(1'b0, `ADCC_A_RESL, 32'h0);
    r = {q2[7:0], q[1:0]};
  endtask

  // Flag is cleared before every restart, as software must
  task convert(input logic [9:0] val);
    ain <= val;
    wr(`ADCC_A_STAT, 32'h1);
    wr(`ADCC_A_MODE, 32'h81);
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    av_req = '0;
    ain = 10'h000;
    nrst = 1'b0;
    n_errors = 0;
    tests_run = 0;
    n_samp = 0;
    seen_set = 0;
    seen_keep = 0;
    vals = '{10'h3ff, 10'h000, 10'h200, 10'h1ff};
    repeat (10) @(posedge clk_sys);
    nrst <= 1'b1;
    cyc(5);
    rd(`ADCC_A_RESH, 32'h0, "reset high result");
    rd(`ADCC_A_RESL, 32'h0, "reset low result");
    rd(`ADCC_A_MODE, 32'h0, "reset mode");
    rd(`ADCC_A_STAT, 32'h0, "reset flag");
    rd(4'h7, 32'h0, "unmapped read");
    chk(irq, 1'b0, "reset irq");
    // Start while disabled must not convert
    ain <= 10'h155;
    wr(`ADCC_A_MODE, 32'h80);
    cyc(50);
    rd(`ADCC_A_MODE, 32'h0, "start ignored");
    rd(`ADCC_A_STAT, 32'h0, "no flag when disabled");
    rd(`ADCC_A_RESH, 32'h0, "no result when disabled");
    // Plain conversion
    wr(`ADCC_A_MASK, 32'h1);
    // Enable first, then let the converter settle before starting
    wr(`ADCC_A_MODE, 32'h1);
    cyc(10);
    base = n_samp;
    wr(`ADCC_A_MODE, 32'h81);
    wait_irq();
    rd(`ADCC_A_MODE, 32'h1, "start self-clears");
    rd(`ADCC_A_STAT, 32'h1, "done flag");
    rd(`ADCC_A_RESH, 32'h55, "high result");
    rd(`ADCC_A_RESL, 32'h1, "low result");
    chk(32'(n_samp - base), 32'h4, "sampling cycles");
    // Channel and port-analog writes keep flag and result
    wr(`ADCC_A_CHAN, 32'h5);
    wr(`ADCC_A_PMODE, 32'ha5);
    rd(`ADCC_A_STAT, 32'h1, "flag kept on channel write");
    chk(chan, 3'h5, "channel port");
    chk(pmode, 8'ha5, "port mode port");
    rd(`ADCC_A_CHAN, 32'h5, "channel readback");
    rd(`ADCC_A_PMODE, 32'ha5, "port mode readback");
    rd(`ADCC_A_RESH, 32'h55, "result kept");
    // Mask, write-zero and write-one-to-clear
    wr(`ADCC_A_MASK, 32'h0);
    cyc(2);
    chk(irq, 1'b0, "masked irq");
    wr(`ADCC_A_STAT, 32'h0);
    rd(`ADCC_A_STAT, 32'h1, "zero write keeps flag");
    wr(`ADCC_A_MASK, 32'h1);
    cyc(2);
    chk(irq, 1'b1, "unmasked irq");
    wr(`ADCC_A_STAT, 32'h1);
    cyc(2);
    chk(irq, 1'b0, "cleared irq");
    rd(`ADCC_A_STAT, 32'h0, "flag cleared");
    // Abort mid-conversion
    convert(10'h3ff);
    cyc(10);
    wr(`ADCC_A_MODE, 32'h1);
    cyc(50);
    rd(`ADCC_A_STAT, 32'h0, "abort leaves no flag");
    rd(`ADCC_A_RESH, 32'h55, "abort keeps result");
    rd(`ADCC_A_MODE, 32'h1, "standby after abort");
    // Code extremes and the two codes either side of mid-scale through the bit decisions
    foreach (vals[i])
    begin
      convert(vals[i]);
      wait_irq();
      read_result();
      chk(r, vals[i], "converted code");
    end
    prev = vals[3];
    // Result read swept across the end of conversion
    for (int off = 24; off <= 40; off++)
    begin
      v = 10'(10'h0c3 + off * 29);
      convert(v);
      cyc(off);
      acc(1'b0, `ADCC_A_RESH, 32'h0);
      // Read still up at the done edge sees the old result
      r = (off <= 33) ? prev : v;
      chk(q, {24'h0, r[9:2]}, "read during result update");
      wait_irq();
      read_result();
      chk(r, v, "result after colliding read");
      prev = v;
    end
    // Mode write swept across the end of conversion
    for (int off = 24; off <= 40; off++)
    begin
      v = 10'(10'h2e1 + off * 37);
      convert(v);
      cyc(off);
      wr(`ADCC_A_MODE, 32'h1);
      cyc(50);
      acc(1'b0, `ADCC_A_STAT, 32'h0);
      ok = q[0];
      chk(ok, (off == 31 || off >= 33), "flag versus mode write");
      read_result();
      chk(r, ok ? v : prev, "mode write versus result");
      if (ok === 1'b1)
        seen_set++;
      else
        seen_keep++;
      if (ok === 1'b1)
        prev = v;
    end
    chk(seen_set > 0 && seen_keep > 0, 1'b1, "both outcomes seen");
    // Stop and disable before any low-power entry
    wr(`ADCC_A_MODE, 32'h0);
    rd(`ADCC_A_MODE, 32'h0, "stopped and disabled");
    complete_run();
  end
endmodule
